// ---- power_mode_reset_pkg.sv ----
package power_mode_reset_pkg;

  // Register byte offsets on the APB window
  localparam logic [11:0] OFS_CONST_LAT_TASK = 12'h078;
  localparam logic [11:0] OFS_LOW_POWER_TASK = 12'h07C;
  localparam logic [11:0] OFS_PWR_FAIL_EVENT = 12'h108;
  localparam logic [11:0] OFS_RESET_REASON = 12'h400;
  localparam logic [11:0] OFS_OFF_MODE_REQ = 12'h500;
  localparam logic [11:0] OFS_PWR_FAIL_CFG = 12'h510;
  localparam logic [11:0] OFS_RESET_PIN_SEL = 12'h530;
  localparam logic [11:0] OFS_SWITCH_REG_EN = 12'h578;
  localparam logic [11:0] OFS_STATUS = 12'h600;
  localparam logic [11:0] OFS_RAM_BASE = 12'h900;
  localparam logic [11:0] OFS_RAM_STRIDE = 12'h010;
  localparam logic [11:0] OFS_RAM_SET = 12'h004;
  localparam logic [11:0] OFS_RAM_CLR = 12'h008;

  // RAM sections and their power register layout
  localparam int RAM_SECTIONS = 3;
  localparam int RAM_POWER_BIT = 0;
  localparam int RAM_RETAIN_BIT = 16;
  localparam logic [31:0] RAM_REG_MASK = 32'h0001_0001;
  localparam logic [31:0] RAM_REG_RESET = 32'h0001_0001;

  // Reset reason bit positions
  localparam int RR_PIN = 0;
  localparam int RR_WATCHDOG = 1;
  localparam int RR_SOFT = 2;
  localparam int RR_WAKE_OFF = 3;
  localparam int RR_WIDTH = 4;

  // Power-fail comparator configuration fields
  localparam int PF_ENABLE_BIT = 0;
  localparam int PF_THR_LSB = 1;
  localparam int PF_THR_WIDTH = 4;
  localparam logic [3:0] PF_THR_RESET = 4'h0;

  // Reset pin select fields; bit 31 set means disconnected
  localparam int PIN_SEL_WIDTH = 5;
  localparam int PIN_DISCONNECT_BIT = 31;
  localparam logic [31:0] PIN_SEL_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] PIN_RESET_CAPABLE = 32'h0000_FFFF;

  // Status register fields
  localparam int ST_CONST_LAT = 0;
  localparam int ST_OFF_EMUL = 1;
  localparam int ST_PF_ACTIVE = 2;
  localparam int ST_SWITCH_REG = 3;

  // Length of an internally generated reset pulse
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RESET_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_WIDTH = 8;

  // Global power states, one-hot
  typedef enum logic [2:0] {
    PS_ON = 3'b001,
    PS_OFF = 3'b010,
    PS_OFF_EMUL = 3'b100
  } pwr_state_e;

endpackage

// ---- power_mode_reset_ctrl.sv ----
`timescale 1ns/10ps
// Overview of operation
// - Linear regulator after reset; switching regulator only once software enables it.
// - Off-mode write powers core down and terminates every running task.
// - Off state wakes only on pin detect or a reset.
// - Wakeup from off is a device reset and sets its reset-reason bit.
// - RAM section power registers survive off state and ordinary resets.
// - In debug mode the off request is emulated; everything stays powered.
// - After power-on reset the device is in the on state.
// - Reset or wake cause is readable in the reset-reason register.
// - Constant-latency task selects sub-mode keeping base resources on in sleep.
// - Low-power task selects automatic, most efficient supply sub-mode.
// - On entry the sub-mode is low-power; sub-mode matters only when all idle.
// - Enabled comparator raises warning on fall, at enable, or on threshold raise.
// - Enabled and below threshold blocks flash writes; never resets the system.
// - Comparator inactive in off state and while the fast clock is stopped.
// - Powered section is accessible and retained outside off state; otherwise retained only if retention set.
// - Power-on reset held until supply is valid and regulators started.
// - Selected reset pin resets the device; only capable pins may serve.
// - Wake from off in debug mode leaves the debug access port out of reset.
// - Soft reset from core reset request bit or control access port write.
// - Watchdog timeout and brownout both reset the device.
// - Brownout or power-on clears reset reason; other resets leave it.
module power_mode_reset_ctrl
  import power_mode_reset_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supplyAtMinimum,
  input wire logic regulatorsStarted,
  input wire logic brownoutDetect,
  input wire logic watchdogTimeout,
  input wire logic systemResetRequestBit,
  input wire logic controlAccessPortReset,
  input wire logic wakeDetect,
  input wire logic [31:0] gpioIn,
  input wire logic debugMode,
  input wire logic highFrequencyClockRunning,
  input wire logic supplyBelowThreshold,
  input wire logic cpuIdle,
  input wire logic peripheralsIdle,
  output logic systemReset,
  output logic debugAccessPortReset,
  output logic switchingRegulatorSelect,
  output logic coreOff,
  output logic terminateTasks,
  output logic constantLatencyActive,
  output logic powerFailWarningEvent,
  output logic [PF_THR_WIDTH-1:0] powerFailThreshold,
  output logic nonvolatileWriteBlock,
  output logic [RAM_SECTIONS-1:0] ramAccessible,
  output logic [RAM_SECTIONS-1:0] ramRetained
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  pwr_state_e pwrState_reg;
  pwr_state_e pwrState_next;
  logic [RESET_CNT_WIDTH-1:0] resetCnt_reg;
  logic dbgInReset_reg;
  logic [RR_WIDTH-1:0] resetReason_reg;
  logic switchEn_reg;
  logic pfEnable_reg;
  logic [PF_THR_WIDTH-1:0] pfThreshold_reg;
  logic constant_latency_task_reg;
  logic pfEvent_reg;
  logic pfPulse_reg;
  logic pfWarnPrev_reg;
  logic terminate_reg;
  logic [31:0] pinSel_reg;
  logic [31:0] ramPower_reg [RAM_SECTIONS];
  logic [31:0] prdata_reg;
  logic setupPhase;
  logic wrAccess;
  logic porHold;
  logic resetBusy;
  logic pinReset;
  logic watchdogTrig;
  logic softTrig;
  logic wakeTrig;
  logic anyTrig;
  logic offWrite;
  logic pfActive;
  logic pfWarn;
  logic [RAM_SECTIONS-1:0] ramHit;
  logic addrMapped;
  logic [31:0] readMux;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode; zero wait states, the answer comes in the access cycle

  assign setupPhase = ce && psel && !penable;
  assign wrAccess = ce && psel && penable && pwrite;
  assign pready = ce && psel && penable;
  assign prdata = prdata_reg;

  // Read mux, also used to flag unmapped addresses
  always_comb begin
    readMux = 32'h0000_0000;
    addrMapped = 1'b1;
    ramHit = '0;
    for (int i = 0; i < RAM_SECTIONS; i++) begin
      if (paddr == OFS_RAM_BASE + 12'(i) * OFS_RAM_STRIDE) begin
        ramHit[i] = 1'b1;
      end
    end
    unique case (paddr)
      OFS_CONST_LAT_TASK, OFS_LOW_POWER_TASK, OFS_OFF_MODE_REQ: readMux = 32'h0000_0000;
      OFS_PWR_FAIL_EVENT: readMux = {31'h0, pfEvent_reg};
      OFS_RESET_REASON: readMux = {{(32 - RR_WIDTH){1'b0}}, resetReason_reg};
      OFS_PWR_FAIL_CFG: readMux = {27'h0, pfThreshold_reg, pfEnable_reg};
      OFS_RESET_PIN_SEL: readMux = pinSel_reg;
      OFS_SWITCH_REG_EN: readMux = {31'h0, switchEn_reg};
      OFS_STATUS: readMux = {28'h0, switchEn_reg, pfActive,
                             pwrState_reg == PS_OFF_EMUL, constant_latency_task_reg};
      default: begin
        addrMapped = 1'b0;
        for (int i = 0; i < RAM_SECTIONS; i++) begin
          for (int k = 0; k < 3; k++) begin
            if (paddr == OFS_RAM_BASE + 12'(i) * OFS_RAM_STRIDE + 12'(k * 4)) begin
              addrMapped = 1'b1;
              readMux = ramPower_reg[i];
            end
          end
        end
      end
    endcase
  end

  assign pslverr = pready && !addrMapped;

  // Read data captured in the setup cycle so it stands from a flip-flop
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setupPhase && !pwrite) begin
      prdata_reg <= readMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset sources

  // Power-on hold until supply and regulators are good
  assign porHold = !(supplyAtMinimum && regulatorsStarted);
  assign pinReset = !pinSel_reg[PIN_DISCONNECT_BIT]
                    && PIN_RESET_CAPABLE[pinSel_reg[PIN_SEL_WIDTH-1:0]]
                    && !gpioIn[pinSel_reg[PIN_SEL_WIDTH-1:0]];
  // Watchdog is not running in the off state
  assign watchdogTrig = watchdogTimeout && pwrState_reg != PS_OFF;
  assign softTrig = systemResetRequestBit || controlAccessPortReset;
  // Only the detect line wakes; a pin reset wakes through its own path
  assign wakeTrig = wakeDetect && pwrState_reg != PS_ON;
  assign anyTrig = pinReset || watchdogTrig || softTrig || wakeTrig;
  assign resetBusy = resetCnt_reg != '0;
  assign systemReset = porHold || brownoutDetect || resetBusy;
  // Debug port stays out of soft resets and debug-mode wakes
  assign debugAccessPortReset = porHold || brownoutDetect || (resetBusy && dbgInReset_reg);

  // Pulse stretcher; a new trigger restarts the pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      resetCnt_reg <= '0;
    end else if (ce) begin
      if (anyTrig) begin
        resetCnt_reg <= RESET_CNT_WIDTH'(RESET_CYCLES);
      end else if (resetBusy) begin
        resetCnt_reg <= resetCnt_reg - 1'b1;
      end
    end
  end

  // Whether the running pulse also resets the debug port
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dbgInReset_reg <= 1'b0;
    end else if (ce && anyTrig) begin
      dbgInReset_reg <= pinReset || watchdogTrig || (wakeTrig && !debugMode);
    end
  end

  // Reset reason: set wins over write-one-to-clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      resetReason_reg <= '0;
    end else if (ce) begin
      if (porHold || brownoutDetect) begin
        resetReason_reg <= '0;
      end else begin
        for (int b = 0; b < RR_WIDTH; b++) begin
          if (wrAccess && paddr == OFS_RESET_REASON && pwdata[b]) begin
            resetReason_reg[b] <= 1'b0;
          end
        end
        if (pinReset) begin
          resetReason_reg[RR_PIN] <= 1'b1;
        end
        if (watchdogTrig) begin
          resetReason_reg[RR_WATCHDOG] <= 1'b1;
        end
        if (softTrig) begin
          resetReason_reg[RR_SOFT] <= 1'b1;
        end
        if (wakeTrig) begin
          resetReason_reg[RR_WAKE_OFF] <= 1'b1;
        end
      end
    end
  end

  // Pin select survives functional resets
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinSel_reg <= PIN_SEL_RESET;
    end else if (ce) begin
      if (brownoutDetect) begin
        pinSel_reg <= PIN_SEL_RESET;
      end else if (wrAccess && paddr == OFS_RESET_PIN_SEL) begin
        pinSel_reg <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Global power state

  assign offWrite = wrAccess && paddr == OFS_OFF_MODE_REQ && pwdata[0];

  always_comb begin
    pwrState_next = pwrState_reg;
    unique case (pwrState_reg)
      PS_ON: begin
        if (offWrite) begin
          pwrState_next = debugMode ? PS_OFF_EMUL : PS_OFF;
        end
      end
      PS_OFF, PS_OFF_EMUL: begin
        pwrState_next = pwrState_reg; // Left only through a reset
      end
      default: pwrState_next = PS_ON;
    endcase
  end

  // Any reset returns to the on state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pwrState_reg <= PS_ON;
    end else if (ce) begin
      pwrState_reg <= (systemReset || anyTrig) ? PS_ON : pwrState_next;
    end
  end

  // One-cycle abort strobe to all task logic on real off entry
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      terminate_reg <= 1'b0;
    end else if (ce) begin
      terminate_reg <= pwrState_reg == PS_ON && pwrState_next == PS_OFF && !systemReset
                       && !anyTrig;
    end
  end

  assign coreOff = pwrState_reg == PS_OFF;
  assign terminateTasks = terminate_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Regulator select and sub-modes

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      switchEn_reg <= 1'b0;
    end else if (ce) begin
      if (systemReset) begin
        switchEn_reg <= 1'b0;
      end else if (wrAccess && paddr == OFS_SWITCH_REG_EN) begin
        switchEn_reg <= pwdata[0];
      end
    end
  end

  assign switchingRegulatorSelect = switchEn_reg;

  // Low-power is the default on every on-state entry
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      constant_latency_task_reg <= 1'b0;
    end else if (ce) begin
      if (systemReset) begin
        constant_latency_task_reg <= 1'b0;
      end else if (wrAccess && paddr == OFS_CONST_LAT_TASK && pwdata[0]) begin
        constant_latency_task_reg <= 1'b1;
      end else if (wrAccess && paddr == OFS_LOW_POWER_TASK && pwdata[0]) begin
        constant_latency_task_reg <= 1'b0;
      end
    end
  end

  // Sub-mode only shows while everything sleeps
  assign constantLatencyActive = constant_latency_task_reg && cpuIdle && peripheralsIdle;

  ////////////////////////////////////////////////////////////////////////////////
  // Power-fail comparator

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pfEnable_reg <= 1'b0;
      pfThreshold_reg <= PF_THR_RESET;
    end else if (ce) begin
      if (systemReset) begin
        pfEnable_reg <= 1'b0;
        pfThreshold_reg <= PF_THR_RESET;
      end else if (wrAccess && paddr == OFS_PWR_FAIL_CFG) begin
        pfEnable_reg <= pwdata[PF_ENABLE_BIT];
        pfThreshold_reg <= pwdata[PF_THR_LSB +: PF_THR_WIDTH];
      end
    end
  end

  assign powerFailThreshold = pfThreshold_reg;
  // Saves power: comparator sleeps when off or fast clock stopped
  assign pfActive = pfEnable_reg && pwrState_reg != PS_OFF && highFrequencyClockRunning;
  assign pfWarn = pfActive && supplyBelowThreshold;
  // Blocks flash writes only; this path never feeds a reset
  assign nonvolatileWriteBlock = pfWarn;

  // Rising warning covers a fall, enabling while low and raising the threshold
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pfWarnPrev_reg <= 1'b0;
      pfPulse_reg <= 1'b0;
    end else if (ce) begin
      pfWarnPrev_reg <= pfWarn;
      pfPulse_reg <= pfWarn && !pfWarnPrev_reg;
    end
  end

  // Sticky event flag; software writes zero to clear, a new event wins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pfEvent_reg <= 1'b0;
    end else if (ce) begin
      if (systemReset) begin
        pfEvent_reg <= 1'b0;
      end else if (pfWarn && !pfWarnPrev_reg) begin
        pfEvent_reg <= 1'b1;
      end else if (wrAccess && paddr == OFS_PWR_FAIL_EVENT && !pwdata[0]) begin
        pfEvent_reg <= 1'b0;
      end
    end
  end

  assign powerFailWarningEvent = pfPulse_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // RAM section power; cleared only by power-on or brownout

  for (genvar g = 0; g < RAM_SECTIONS; g++) begin : g_ram
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        ramPower_reg[g] <= RAM_REG_RESET;
      end else if (ce) begin
        if (brownoutDetect) begin
          ramPower_reg[g] <= RAM_REG_RESET;
        end else if (wrAccess && ramHit[g]) begin
          ramPower_reg[g] <= pwdata & RAM_REG_MASK;
        end else if (wrAccess && paddr == OFS_RAM_BASE + 12'(g) * OFS_RAM_STRIDE + OFS_RAM_SET) begin
          ramPower_reg[g] <= ramPower_reg[g] | (pwdata & RAM_REG_MASK);
        end else if (wrAccess && paddr == OFS_RAM_BASE + 12'(g) * OFS_RAM_STRIDE + OFS_RAM_CLR) begin
          ramPower_reg[g] <= ramPower_reg[g] & ~(pwdata & RAM_REG_MASK);
        end
      end
    end
    assign ramAccessible[g] = ramPower_reg[g][RAM_POWER_BIT] && !coreOff;
    assign ramRetained[g] = ramAccessible[g] || ramPower_reg[g][RAM_RETAIN_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence offRequest_s;
    ce && offWrite && pwrState_reg == PS_ON && !systemReset && !anyTrig;
  endsequence

  sequence offEntered_s;
    pwrState_reg == PS_OFF && terminateTasks;
  endsequence

  regulatorReset_a: assert property (ce && systemReset |=> !switchingRegulatorSelect)
    else $error("switching regulator still selected after reset");
  offEntry_a: assert property (offRequest_s and !debugMode |=> offEntered_s)
    else $error("off request did not power down and terminate tasks");
  offHold_a: assert property (ce && coreOff && !anyTrig && !systemReset |=> coreOff)
    else $error("off state left without wake or reset");
  wakeReset_a: assert property (ce && wakeTrig && !porHold && !brownoutDetect
                                |=> systemReset && resetReason_reg[RR_WAKE_OFF]
                                && pwrState_reg == PS_ON)
    else $error("wake from off was not a recorded reset");
  ramKeep_a: assert property (ce && resetBusy && !brownoutDetect && !wrAccess
                              |=> $stable(ramPower_reg[0]))
    else $error("RAM power register lost across reset");
  emulOff_a: assert property (offRequest_s and debugMode
                              |=> pwrState_reg == PS_OFF_EMUL && !coreOff
                              && !terminateTasks)
    else $error("debug-mode off request powered the core down");
  subModeDefault_a: assert property (ce && systemReset |=> !constant_latency_task_reg)
    else $error("sub-mode not low-power after reset");
  pfEvent_a: assert property (ce && pfWarn && !pfWarnPrev_reg
                              |=> powerFailWarningEvent && pfEvent_reg)
    else $error("power-fail warning missed");
  pfSleep_a: assert property (nonvolatileWriteBlock |-> pfEnable_reg && !coreOff
                              && highFrequencyClockRunning)
    else $error("flash writes blocked by inactive comparator");
  reasonClear_a: assert property (ce && brownoutDetect |=> resetReason_reg == '0)
    else $error("brownout left reset reason set");
  dapKeep_a: assert property (ce && wakeTrig && debugMode && !pinReset && !watchdogTrig
                              && !brownoutDetect && !porHold
                              |=> systemReset && !debugAccessPortReset)
    else $error("debug port reset on debug-mode wake");

endmodule

// ---- side_source_model.sv ----
`timescale 1ns/10ps
// Supervisor, wake detector and watchdog as the block sees them
module side_source_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic wakeReq,
  input wire logic wdtReq,
  output logic supplyAtMinimum,
  output logic regulatorsStarted,
  output logic wakeDetect,
  output logic watchdogTimeout
);
  logic [3:0] rampCnt;
  logic wakeQ;
  logic wdtQ;
  // Supply settles first, regulators start later, so reset release is staggered
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rampCnt <= 4'h0;
    end else if (rampCnt != 4'hF) begin
      rampCnt <= rampCnt + 4'h1;
    end
  end
  assign supplyAtMinimum = rampCnt > 4'h3;
  assign regulatorsStarted = rampCnt > 4'h6;
  // Requests become single-cycle pulses, as real detectors give
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wakeQ <= 1'b0;
      wdtQ <= 1'b0;
    end else begin
      wakeQ <= wakeReq;
      wdtQ <= wdtReq;
    end
  end
  assign wakeDetect = wakeReq & !wakeQ;
  assign watchdogTimeout = wdtReq & !wdtQ;
endmodule

// ---- power_mode_and_reset_control_tb.sv ----
`timescale 1ns/10ps
module power_mode_and_reset_control_tb;
  import power_mode_reset_pkg::*;
  logic core_clk, rstn, ce, psel, penable, pwrite, pready, pslverr, lastErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic supplyAtMinimum, regulatorsStarted, brownoutDetect, watchdogTimeout;
  logic systemResetRequestBit, controlAccessPortReset, wakeDetect, debugMode;
  logic highFrequencyClockRunning, supplyBelowThreshold, cpuIdle, peripheralsIdle;
  logic systemReset, debugAccessPortReset, switchingRegulatorSelect, coreOff;
  logic terminateTasks, constantLatencyActive, powerFailWarningEvent;
  logic nonvolatileWriteBlock, wakeReq, wdtReq;
  logic [31:0] gpioIn;
  logic [PF_THR_WIDTH-1:0] powerFailThreshold;
  logic [RAM_SECTIONS-1:0] ramAccessible, ramRetained;
  int num_errors = 0;
  int checked = 0;
  int evtCnt = 0;
  int termCnt = 0;

  power_mode_reset_ctrl dut (.core_clk, .rstn, .ce, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .supplyAtMinimum, .regulatorsStarted,
    .brownoutDetect, .watchdogTimeout, .systemResetRequestBit, .controlAccessPortReset,
    .wakeDetect, .gpioIn, .debugMode, .highFrequencyClockRunning, .supplyBelowThreshold,
    .cpuIdle, .peripheralsIdle, .systemReset, .debugAccessPortReset,
    .switchingRegulatorSelect, .coreOff, .terminateTasks, .constantLatencyActive,
    .powerFailWarningEvent, .powerFailThreshold, .nonvolatileWriteBlock, .ramAccessible,
    .ramRetained);
  side_source_model partner (.core_clk, .rstn, .wakeReq, .wdtReq, .supplyAtMinimum,
    .regulatorsStarted, .wakeDetect, .watchdogTimeout);

  ////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Pulses are counted so that none slips by between checks
  always @(posedge core_clk) begin
    if (powerFailWarningEvent === 1'b1) evtCnt++;
    if (terminateTasks === 1'b1) termCnt++;
  end

  ////////////////////
  task automatic stop_test();
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Settle one ns past the edge so register updates have landed
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // Only a wait that never saw pready counts as a timeout
    if (pready !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rst();
    int n;
    n = 0;
    while (systemReset !== 1'b0 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 300) begin
      num_errors++;
      stop_test();
    end
    #1;
  endtask

  ////////////////////
  task automatic t_power_on();
    chk("coreOff", coreOff, 0);
    chk("regSel", switchingRegulatorSelect, 0);
    chk("constant_latency_task", constantLatencyActive, 0);
    apb(0, OFS_RAM_BASE, 0);
    chk("ram0", rd, RAM_REG_RESET);
    chk("ramAcc", ramAccessible, 3'h7);
    apb(1, OFS_SWITCH_REG_EN, 1);
    cyc(1);
    chk("regSel", switchingRegulatorSelect, 1);
    apb(0, 12'hFFC, 0);
    chk("unmapped", {rd[30:0], lastErr}, 1);
  endtask
  // Sub-mode shows only while everything is idle
  task automatic t_sub_mode();
    apb(1, OFS_CONST_LAT_TASK, 1);
    cyc(1);
    chk("constant_latency_task busy", constantLatencyActive, 0);
    cpuIdle <= 1'b1;
    cyc(1);
    chk("constant_latency_task", constantLatencyActive, 1);
    apb(1, OFS_LOW_POWER_TASK, 1);
    cyc(1);
    chk("low_power_task", constantLatencyActive, 0);
  endtask
  // Supply already low at enable must still warn
  task automatic t_power_fail();
    supplyBelowThreshold <= 1'b1;
    apb(1, OFS_PWR_FAIL_CFG, 32'h7);
    cyc(3);
    chk("thr", powerFailThreshold, 3);
    chk("warn", evtCnt, 1);
    chk("nvmBlock", nonvolatileWriteBlock, 1);
    chk("noReset", systemReset, 0);
    highFrequencyClockRunning <= 1'b0;
    cyc(3);
    chk("inactive", {nonvolatileWriteBlock, evtCnt[7:0]}, 1);
    highFrequencyClockRunning <= 1'b1;
    cyc(3);
    chk("warn again", evtCnt, 2);
    supplyBelowThreshold <= 1'b0;
    apb(0, OFS_PWR_FAIL_EVENT, 0);
    chk("event flag", rd, 1);
    apb(1, OFS_PWR_FAIL_EVENT, 0);
    apb(0, OFS_PWR_FAIL_EVENT, 0);
    chk("event cleared", rd, 0);
  endtask
  // Reason bits accumulate until a brownout wipes them
  task automatic t_reset_sources();
    wdtReq <= 1'b1;
    cyc(3);
    chk("wdtRst", systemReset, 1);
    wdtReq <= 1'b0;
    wait_rst();
    apb(0, OFS_RESET_REASON, 0);
    chk("reason wdt", rd, 32'h2);
    systemResetRequestBit <= 1'b1;
    cyc(3);
    systemResetRequestBit <= 1'b0;
    wait_rst();
    apb(0, OFS_RESET_REASON, 0);
    chk("reason soft", rd, 32'h6);
    apb(1, OFS_RESET_PIN_SEL, 32'h5);
    gpioIn[5] <= 1'b0;
    cyc(3);
    gpioIn[5] <= 1'b1;
    wait_rst();
    apb(0, OFS_RESET_REASON, 0);
    chk("reason pin", rd, 32'h7);
    brownoutDetect <= 1'b1;
    cyc(3);
    chk("borRst", systemReset, 1);
    brownoutDetect <= 1'b0;
    wait_rst();
    apb(0, OFS_RESET_REASON, 0);
    chk("reason bor", rd, 0);
  endtask
  // Peripherals are idle here, so no transfer is in flight at the off request
  task automatic t_off();
    apb(1, OFS_RAM_BASE + OFS_RAM_CLR, 1);
    apb(1, OFS_OFF_MODE_REQ, 1);
    cyc(1);
    chk("coreOff", coreOff, 1);
    chk("terminate", termCnt, 1);
    chk("ram off", {ramAccessible, ramRetained}, 6'h07);
    wdtReq <= 1'b1;
    cyc(3);
    chk("stay off", {coreOff, systemReset}, 2);
    wdtReq <= 1'b0;
    wakeReq <= 1'b1;
    cyc(3);
    chk("wakeRst", systemReset, 1);
    wakeReq <= 1'b0;
    wait_rst();
    chk("on again", coreOff, 0);
    apb(0, OFS_RESET_REASON, 0);
    chk("reason wake", rd, 32'h8);
    apb(1, OFS_RESET_REASON, 32'h8);
    apb(0, OFS_RESET_REASON, 0);
    chk("reason w1c", rd, 0);
    apb(0, OFS_RAM_BASE, 0);
    chk("ram kept", rd, 32'h0001_0000);
  endtask
  // No bus traffic follows the off request until the wake
  task automatic t_emulated_off();
    debugMode <= 1'b1;
    apb(1, OFS_OFF_MODE_REQ, 1);
    cyc(1);
    chk("emul coreOff", coreOff, 0);
    wakeReq <= 1'b1;
    cyc(3);
    chk("dapKept", {systemReset, debugAccessPortReset}, 2);
    wakeReq <= 1'b0;
    wait_rst();
    debugMode <= 1'b0;
  endtask

  ////////////////////
  initial begin
    {rstn, psel, penable, pwrite, brownoutDetect, systemResetRequestBit} = '0;
    {controlAccessPortReset, debugMode, supplyBelowThreshold, cpuIdle, wakeReq, wdtReq} = '0;
    {ce, highFrequencyClockRunning, peripheralsIdle} = 3'h7;
    {paddr, pwdata, rd} = '0;
    gpioIn = 32'hFFFF_FFFF;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    cyc(1);
    chk("porHold", systemReset, 1);
    wait_rst();
    t_power_on();
    t_sub_mode();
    t_power_fail();
    t_reset_sources();
    t_off();
    t_emulated_off();
    stop_test();
  end
endmodule
